// ==== cce_defines.svh ====
`ifndef CCE_DEFINES_SVH
`define CCE_DEFINES_SVH
// Register addresses on the parallel bus.
`define CCE_ADDR_CLOCK_CONFIG 4'h1
`define CCE_ADDR_ETU_DIVISOR 4'h2
`define CCE_ADDR_UART_CONTROL_TWO 4'h3
`define CCE_ADDR_GUARD_TIME 4'h5
`define CCE_ADDR_TRANSMIT_DATA 4'hD
`define CCE_ADDR_HW_STATUS 4'hF
// Clock configuration field positions.
`define CCE_CCR_STOP_LEVEL 5
`define CCE_CCR_CLOCK_HALT 4
`define CCE_CCR_SYNC_CLOCK 3
`define CCE_CCR_DIV_HI 2
`define CCE_CCR_DIV_LO 0
`define CCE_CCR_RIU_KEEP 8'h3F
// UART control two field positions.
`define CCE_UC2_BUF_IRQ_DIS 6
`define CCE_UC2_AUX_IRQ_DIS 5
`define CCE_UC2_POWER_DOWN 4
`define CCE_UC2_SYNC_ASYNC 3
`define CCE_UC2_CONVENTION_BIT_DET_DIS 2
`define CCE_UC2_ETU_DOUBLER 1
`define CCE_UC2_PRESCALER 0
`define CCE_UC2_WMASK 8'h7F
// Hardware status bit of the auxiliary change flag.
`define CCE_HSR_AUX_CHANGE 1
// Reset values.
`define CCE_REG_RESET 8'h00
// Prescaler figures.
`define CCE_PRESCALE_31 6'd31
`define CCE_PRESCALE_32 6'd32
`endif

// ==== cce_pkg.sv ====
package cce_pkg;
  // Card select field codes.
  typedef enum logic [2:0]
  {
    CCE_SEL_NONE = 3'b000,
    CCE_SEL_A = 3'b001,
    CCE_SEL_B = 3'b010,
    CCE_SEL_AUX = 3'b100
  } cce_card_type;
  typedef logic [7:0] cce_byte_type;
  // Power mode of the block.
  typedef enum logic [1:0] {CCE_PWR_RUN, CCE_PWR_DOWN, CCE_PWR_WAKE} cce_pwr_type;
endpackage

// ==== cce_cfg_if.sv ====
`timescale 1ns/100ps
// Settings that one card slot hands to its clock and ETU generator.
interface cce_cfg_if;
  logic [2:0] div_sel;
  logic halt;
  logic stop_level;
  logic doubler;
  logic prescale_32;
  logic [7:0] divisor;
  logic gate_off;
  logic card_clk;
  logic etu_tick;
  modport ctrl (output div_sel, halt, stop_level, doubler, prescale_32, divisor, gate_off,
    input card_clk, etu_tick);
  modport gen (input div_sel, halt, stop_level, doubler, prescale_32, divisor, gate_off,
    output card_clk, etu_tick);
endinterface

// ==== cce_clkgen.sv ====
`timescale 1ns/100ps
`include "cce_defines.svh"
// Card clock and ETU generator. Both the crystal and the ring oscillator arrive
// as enables sampled on mclk, so every divided clock is a registered toggle.
module cce_clkgen
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Source clock enables.
  input wire logic xtal_tick,
  input wire logic ring_tick,
  // Settings and outputs.
  cce_cfg_if.gen cfg
);
  logic [2:0] div_cnt_r;
  logic ring_cnt_r;
  logic [2:0] div_sel_r;
  logic clk_r;
  logic half_tick;
  logic edge_due;
  logic [5:0] pre_cnt_r;
  logic [7:0] etu_cnt_r;
  logic pre_tick;
  logic [5:0] pre_top;
  logic [7:0] etu_top;

  // A clock edge is due once enough source ticks passed for the selected ratio.
  // One source tick is one half period, so 000 runs at half the source tick rate.
  always_comb
  begin
    half_tick = 1'b0;
    edge_due = 1'b0;
    unique casez (div_sel_r)
      3'b000: edge_due = xtal_tick;
      3'b001: edge_due = xtal_tick && div_cnt_r[0];
      3'b010: edge_due = xtal_tick && (div_cnt_r[1:0] == 2'b11);
      3'b011: edge_due = xtal_tick && (div_cnt_r == 3'b111);
      3'b1??: edge_due = ring_tick && ring_cnt_r;
    endcase
    half_tick = edge_due;
  end

  // The new selection is only taken while the clock is low, so no pulse is cut short.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      div_sel_r <= 3'b000;
    else if (!clk_r && edge_due)
      div_sel_r <= cfg.div_sel;
  end

  // Source tick counter for the slower crystal ratios.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      div_cnt_r <= 3'b000;
    else if (xtal_tick)
      div_cnt_r <= div_cnt_r + 3'b001;
  end

  // Ring tick counter; the ring rate is always halved before it reaches the card.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      ring_cnt_r <= 1'b0;
    else if (ring_tick)
      ring_cnt_r <= ~ring_cnt_r;
  end

  // Card clock toggles, or rests at the stop level when halted or gated.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      clk_r <= 1'b0;
    else if (cfg.halt || cfg.gate_off)
      clk_r <= cfg.stop_level;
    else if (half_tick)
      clk_r <= ~clk_r;
  end

  assign cfg.card_clk = clk_r;

  // Doubler counts each half period instead of each full one, except at the crystal rate.
  always_comb
  begin
    pre_tick = 1'b0;
    if (!cfg.gate_off && !cfg.halt)
    begin
      if (cfg.doubler && cfg.div_sel != 3'b000)
        pre_tick = half_tick;
      else
        pre_tick = half_tick && clk_r;
    end
  end

  // Prescaler of 31 or 32 card clocks.
  assign pre_top = cfg.prescale_32 ? `CCE_PRESCALE_32 : `CCE_PRESCALE_31;
  // Divisor values below two divide by one.
  assign etu_top = (cfg.divisor < 8'h02) ? 8'h01 : cfg.divisor;

  // Prescaler counter.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      pre_cnt_r <= 6'd0;
    else if (pre_tick)
      pre_cnt_r <= (pre_cnt_r + 6'd1 >= pre_top) ? 6'd0 : pre_cnt_r + 6'd1;
  end

  // ETU counter; one tick per completed ETU.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      etu_cnt_r <= 8'h00;
    else if (pre_tick && (pre_cnt_r + 6'd1 >= pre_top))
      etu_cnt_r <= (etu_cnt_r + 8'h01 >= etu_top) ? 8'h00 : etu_cnt_r + 8'h01;
  end

  assign cfg.etu_tick = pre_tick && (pre_cnt_r + 6'd1 >= pre_top)
    && (etu_cnt_r + 8'h01 >= etu_top);
endmodule // cce_clkgen

// ==== cce_guard.sv ====
`timescale 1ns/100ps
// Counts extra guard ETUs before a character leaves the transmit register.
module cce_guard
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Request and timing.
  input wire logic char_start,
  input wire logic [7:0] guard_etus,
  input wire logic etu_tick,
  // Release to the framer.
  output logic send_go
);
  logic [7:0] left_r;
  logic wait_r;

  // Load on a new character, count ETUs down, release when none remain.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      left_r <= 8'h00;
      wait_r <= 1'b0;
      send_go <= 1'b0;
    end
    else
    begin
      send_go <= 1'b0;
      if (char_start)
      begin
        left_r <= guard_etus;
        wait_r <= 1'b1;
      end
      else if (wait_r && left_r == 8'h00)
      begin
        wait_r <= 1'b0;
        send_go <= 1'b1;
      end
      else if (wait_r && etu_tick)
        left_r <= left_r - 8'h01;
    end
  end
endmodule // cce_guard

// ==== cce_card_config.sv ====
`timescale 1ns/100ps
`include "cce_defines.svh"
// Contract
// - Halted clock rests at stop level.
// - Halt bit stops clock; else divider runs; only the selected slot's contact gets it, the other rests at stop level.
// - Sync card clock copies level bit.
// - Sync mode moves data LSb to/from I/O.
// - Divider field picks crystal or ring rate.
// - Divider changes without glitches.
// - Divisor below two divides by one.
// - Prescaler divides by 31 or 32.
// - Doubler halves ETU except crystal rate.
// - Buffer flag interrupts unless disabled.
// - Aux pin change interrupts unless disabled.
// - Aux change flag latches always.
// - Power-down gates UART, ETU, timeout clocks.
// - Listed events end power-down.
// - Interrupt held until status read.
// - Sync mode bypasses UART.
// - Aux slot sync routes I/O only.
// - Hardware sets convention unless disabled.
// - Guard ETUs precede each character.
// - UART reset clears reserved clock bits.
// - Card select picks register instance.
module cce_card_config
  import cce_pkg::*;
#(
  parameter int SLOTS = 3
)
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Parallel bus, strobes already qualified by chip select.
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic chip_sel_n,
  // Shared control from outside this block.
  input wire cce_pkg::cce_card_type card_select_field,
  input wire logic uart_reset_bit_n,
  input wire logic supply_fault_latch,
  input wire logic card_a_presence_change,
  input wire logic card_b_presence_change,
  // Source clocks as enables.
  input wire logic xtal_tick,
  input wire logic ring_tick,
  // UART side.
  input wire logic buffer_flag,
  input wire logic convention_bit_detect_valid,
  input wire logic convention_bit_detect_value,
  input wire logic convention_setting,
  output logic convention_bit,
  output logic uart_send_go,
  output logic uart_clock_gate,
  output logic etu_tick,
  // Pins.
  input wire logic aux_interrupt_input,
  output logic irq_n,
  output logic xtal_stop,
  output logic [1:0] card_clock_contact,
  input wire logic [2:0] card_io_in,
  output logic [2:0] card_io_out,
  output logic [2:0] card_io_oe_n
);
  import cce_pkg::*;

  cce_byte_type ccr_r [SLOTS];
  cce_byte_type pdr_r [SLOTS];
  cce_byte_type uc2_r [SLOTS];
  cce_byte_type gtr_r [SLOTS];
  logic [2:0] tx_lsb_r;
  logic convention_bit_r;
  logic [1:0] aux_sync_r;
  logic aux_last_r;
  logic aux_flag_r;
  logic aux_armed_r;
  logic [1:0] io_sync0_r, io_sync1_r, io_sync2_r;
  logic [1:0] cs_sync_r;
  logic cs_seen_high_r;
  logic wake_irq_r;
  cce_pwr_type pwr_r;
  logic [1:0] slot;
  logic sel_valid;
  logic aux_change;
  logic status_rd;
  logic wake_event;
  logic sync_mode;
  logic [2:0] io_now;
  cce_byte_type uc2_cur;

  // The card select field names one slot; shared addresses reach only that slot.
  always_comb
  begin
    slot = 2'd0;
    sel_valid = 1'b1;
    unique case (card_select_field)
      CCE_SEL_A: slot = 2'd0;
      CCE_SEL_B: slot = 2'd1;
      CCE_SEL_AUX: slot = 2'd2;
      default: sel_valid = 1'b0;
    endcase
  end

  assign uc2_cur = uc2_r[slot];
  assign sync_mode = uc2_cur[`CCE_UC2_SYNC_ASYNC];
  assign status_rd = bus_rd && bus_addr == `CCE_ADDR_HW_STATUS;

  // Configuration registers. UART reset only clears the reserved clock bits.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < SLOTS; i++)
      begin
        ccr_r[i] <= `CCE_REG_RESET;
        pdr_r[i] <= `CCE_REG_RESET;
        uc2_r[i] <= `CCE_REG_RESET;
        gtr_r[i] <= `CCE_REG_RESET;
      end
    end
    else
    begin
      if (!uart_reset_bit_n)
        ccr_r[slot] <= ccr_r[slot] & `CCE_CCR_RIU_KEEP;
      if (bus_wr && sel_valid)
      begin
        unique case (bus_addr)
          `CCE_ADDR_CLOCK_CONFIG: ccr_r[slot] <= bus_wdata & `CCE_CCR_RIU_KEEP;
          `CCE_ADDR_ETU_DIVISOR: pdr_r[slot] <= bus_wdata;
          // Power-down is refused while a supply fault stays latched.
          `CCE_ADDR_UART_CONTROL_TWO: uc2_r[slot] <= (bus_wdata & `CCE_UC2_WMASK)
            & ~({7'h00, supply_fault_latch} << `CCE_UC2_POWER_DOWN);
          `CCE_ADDR_GUARD_TIME: gtr_r[slot] <= bus_wdata;
          default: ;
        endcase
      end
      if (pwr_r == CCE_PWR_WAKE)
        uc2_r[slot][`CCE_UC2_POWER_DOWN] <= 1'b0;
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb
  begin
    bus_rdata = 8'h00;
    if (sel_valid)
    begin
      unique case (bus_addr)
        `CCE_ADDR_CLOCK_CONFIG: bus_rdata = ccr_r[slot];
        `CCE_ADDR_ETU_DIVISOR: bus_rdata = pdr_r[slot];
        `CCE_ADDR_UART_CONTROL_TWO: bus_rdata = uc2_r[slot];
        `CCE_ADDR_GUARD_TIME: bus_rdata = gtr_r[slot];
        `CCE_ADDR_TRANSMIT_DATA: bus_rdata = {7'h00, sync_mode & io_now[slot]};
        default: bus_rdata = 8'h00;
      endcase
    end
    if (status_rd)
      bus_rdata = {6'h00, aux_flag_r, 1'b0} ;
  end

  // Two-flop synchronisers for the card I/O, chip select and auxiliary pin.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      io_sync0_r <= 2'b00;
      io_sync1_r <= 2'b00;
      io_sync2_r <= 2'b00;
      cs_sync_r <= 2'b11;
      aux_sync_r <= 2'b00;
    end
    else
    begin
      io_sync0_r <= {io_sync0_r[0], card_io_in[0]};
      io_sync1_r <= {io_sync1_r[0], card_io_in[1]};
      io_sync2_r <= {io_sync2_r[0], card_io_in[2]};
      cs_sync_r <= {cs_sync_r[0], chip_sel_n};
      aux_sync_r <= {aux_sync_r[0], aux_interrupt_input};
    end
  end
  assign io_now = {io_sync2_r[1], io_sync1_r[1], io_sync0_r[1]};

  // Sync transmit: the data LSb drives the I/O pin directly; open drain, low only.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      tx_lsb_r <= 3'b111;
    else if (bus_wr && sel_valid && bus_addr == `CCE_ADDR_TRANSMIT_DATA && sync_mode)
      tx_lsb_r[slot] <= bus_wdata[0];
  end
  assign card_io_out = 3'b000;
  always_comb
  begin
    for (int i = 0; i < SLOTS; i++)
      card_io_oe_n[i] = !(uc2_r[i][`CCE_UC2_SYNC_ASYNC] && !tx_lsb_r[i]);
  end

  // Auxiliary change flag: set wins over the clearing status read.
  assign aux_change = aux_sync_r[1] ^ aux_last_r;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      aux_last_r <= 1'b0;
      aux_flag_r <= 1'b0;
      aux_armed_r <= 1'b0;
    end
    else
    begin
      aux_last_r <= aux_sync_r[1];
      if (aux_change)
        aux_flag_r <= 1'b1;
      else if (status_rd)
        aux_flag_r <= 1'b0;
      // Only a fresh set after a clear may end power-down.
      if (!aux_flag_r)
        aux_armed_r <= 1'b1;
      else if (pwr_r == CCE_PWR_RUN)
        aux_armed_r <= 1'b0;
    end
  end

  // Chip select must be seen released after entry before a reassertion counts.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      cs_seen_high_r <= 1'b0;
    else if (pwr_r != CCE_PWR_DOWN)
      cs_seen_high_r <= 1'b0;
    else if (cs_sync_r[1])
      cs_seen_high_r <= 1'b1;
  end

  assign wake_event = card_a_presence_change || card_b_presence_change
    || (cs_seen_high_r && !cs_sync_r[1]) || (aux_change && aux_armed_r)
    || !uc2_cur[`CCE_UC2_POWER_DOWN];

  // Power mode: down while the bit is set, then one cycle to clear it on exit.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      pwr_r <= CCE_PWR_RUN;
    else
    begin
      unique case (pwr_r)
        CCE_PWR_RUN: if (uc2_cur[`CCE_UC2_POWER_DOWN]) pwr_r <= CCE_PWR_DOWN;
        CCE_PWR_DOWN: if (wake_event) pwr_r <= CCE_PWR_WAKE;
        CCE_PWR_WAKE: pwr_r <= CCE_PWR_RUN;
      endcase
    end
  end
  assign xtal_stop = pwr_r == CCE_PWR_DOWN;
  assign uart_clock_gate = pwr_r == CCE_PWR_DOWN;

  // Interrupt held low from wake until the status register is read.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      wake_irq_r <= 1'b0;
    else if (pwr_r == CCE_PWR_WAKE)
      wake_irq_r <= 1'b1;
    else if (status_rd)
      wake_irq_r <= 1'b0;
  end
  assign irq_n = !(wake_irq_r
    || (buffer_flag && !uc2_cur[`CCE_UC2_BUF_IRQ_DIS])
    || (aux_flag_r && !uc2_cur[`CCE_UC2_AUX_IRQ_DIS]));

  // Convention bit: hardware writes it while detection is enabled and armed.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      convention_bit_r <= 1'b0;
    else if (!uc2_cur[`CCE_UC2_CONVENTION_BIT_DET_DIS] && convention_setting && convention_bit_detect_valid)
      convention_bit_r <= convention_bit_detect_value;
  end
  assign convention_bit = convention_bit_r;

  // Clock and ETU generation for the selected slot only.
  cce_cfg_if gen_cfg ();
  assign gen_cfg.div_sel = ccr_r[slot][`CCE_CCR_DIV_HI:`CCE_CCR_DIV_LO];
  assign gen_cfg.halt = ccr_r[slot][`CCE_CCR_CLOCK_HALT] || !sel_valid;
  assign gen_cfg.stop_level = ccr_r[slot][`CCE_CCR_STOP_LEVEL];
  assign gen_cfg.doubler = uc2_cur[`CCE_UC2_ETU_DOUBLER];
  assign gen_cfg.prescale_32 = uc2_cur[`CCE_UC2_PRESCALER];
  assign gen_cfg.divisor = pdr_r[slot];
  assign gen_cfg.gate_off = pwr_r == CCE_PWR_DOWN || sync_mode;

  cce_clkgen u_clkgen
  (
    .mclk(mclk),
    .rst(rst),
    .xtal_tick(xtal_tick),
    .ring_tick(ring_tick),
    .cfg(gen_cfg)
  );
  assign etu_tick = gen_cfg.etu_tick;

  // Card clock contacts: sync mode copies the level bit, otherwise the generator for the selected slot, else the stop level.
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (uc2_r[i][`CCE_UC2_SYNC_ASYNC])
        card_clock_contact[i] = ccr_r[i][`CCE_CCR_SYNC_CLOCK];
      else if (sel_valid && slot == i[1:0])
        card_clock_contact[i] = gen_cfg.card_clk;
      else
        card_clock_contact[i] = ccr_r[i][`CCE_CCR_STOP_LEVEL];
    end
  end

  // Guard time before each asynchronous character.
  cce_guard u_guard
  (
    .mclk(mclk),
    .rst(rst),
    .char_start(bus_wr && sel_valid && bus_addr == `CCE_ADDR_TRANSMIT_DATA && !sync_mode),
    .guard_etus(gtr_r[slot]),
    .etu_tick(gen_cfg.etu_tick),
    .send_go(uart_send_go)
  );
endmodule // cce_card_config

// ==== cce_card_config_props.sv ====
`timescale 1ns/100ps
// Watches the bus and pin side of one card configuration block.
module cce_card_config_props
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Bus and shared control.
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire cce_pkg::cce_card_type card_select_field,
  input wire logic supply_fault_latch,
  // Outputs under watch.
  input wire logic uart_send_go,
  input wire logic uart_clock_gate,
  input wire logic etu_tick,
  input wire logic xtal_stop,
  input wire logic [1:0] card_clock_contact,
  input wire logic [2:0] card_io_out
);
  import cce_pkg::*;
  default clocking dc @(posedge mclk); endclocking
  default disable iff (rst);
  logic sel_ok;
  // A write only lands when one slot is selected.
  assign sel_ok = card_select_field inside {CCE_SEL_A, CCE_SEL_B, CCE_SEL_AUX};
  property p_gate_etu;
    uart_clock_gate |-> !etu_tick;
  endproperty
  a_gate_etu: assert property (p_gate_etu) else $error("ETU tick while gated");
  property p_gate_xtal;
    xtal_stop |-> uart_clock_gate;
  endproperty
  a_gate_xtal: assert property (p_gate_xtal) else $error("UART clock runs in power-down");
  property p_pd_enter;
    !supply_fault_latch && sel_ok && bus_wr && bus_addr == 4'h3 && bus_wdata[4] && !xtal_stop
      |=> ##1 xtal_stop;
  endproperty
  a_pd_enter: assert property (p_pd_enter) else $error("power-down not entered");
  property p_pd_refuse;
    supply_fault_latch && !xtal_stop |=> !xtal_stop;
  endproperty
  a_pd_refuse: assert property (p_pd_refuse) else $error("power-down despite fault");
  property p_ccr_back;
    sel_ok && bus_wr && bus_addr == 4'h1 ##2 bus_rd && bus_addr == 4'h1
      && card_select_field == $past(card_select_field, 2)
      |-> bus_rdata == ($past(bus_wdata, 2) & 8'h3F);
  endproperty
  a_ccr_back: assert property (p_ccr_back) else $error("clock config readback wrong");
  property p_none_read;
    bus_rd && card_select_field == CCE_SEL_NONE && bus_addr inside {4'h1, 4'h2, 4'h3, 4'h5}
      |-> bus_rdata == 8'h00;
  endproperty
  a_none_read: assert property (p_none_read) else $error("read without slot not zero");
  property p_go_pulse;
    uart_send_go |=> !uart_send_go;
  endproperty
  a_go_pulse: assert property (p_go_pulse) else $error("send release too long");
  property p_io_od;
    card_io_out == 3'b000;
  endproperty
  a_io_od: assert property (p_io_od) else $error("I/O driven high");
  property p_clk_width;
    $changed(card_clock_contact[0]) && !$past(bus_wr) && !$past(bus_wr, 2)
      |=> $stable(card_clock_contact[0]);
  endproperty
  a_clk_width: assert property (p_clk_width) else $error("card clock glitch");
  c_pd: cover property ($rose(xtal_stop));
  c_go: cover property (uart_send_go);
  c_status: cover property (bus_rd && bus_addr == 4'hF);
endmodule // cce_card_config_props
bind cce_card_config cce_card_config_props u_props (.*);

// ==== cce_card_model.sv ====
`timescale 1ns/100ps
// Card side of the contacts: open-drain I/O lines with pull-ups.
module cce_card_model
(
  // Contacts.
  input wire logic [2:0] card_io_oe_n,
  output logic [2:0] card_io_in,
  // Bench command for the card pulling a line low.
  input wire logic [2:0] card_pull
);
  // A released line floats up to the pull-up, never holds its old value.
  assign card_io_in = ~(~card_io_oe_n | card_pull);
endmodule // cce_card_model

// ==== tb_top.sv ====
`timescale 1ns/100ps
// Self-checking bench for the card configuration block.
module tb_top;
  import cce_pkg::*;
  logic mclk = 0, rst = 1, bus_wr = 0, bus_rd = 0, chip_sel_n = 0, uart_reset_bit_n = 1;
  logic supply_fault_latch = 0, card_a_presence_change = 0, card_b_presence_change = 0;
  logic xtal_tick = 0, ring_tick = 0, buffer_flag = 0, convention_bit_detect_valid = 0;
  logic convention_bit_detect_value = 0, convention_setting = 0, aux_interrupt_input = 0, meas = 0;
  logic convention_bit, uart_send_go, uart_clock_gate, etu_tick, irq_n, xtal_stop, oen = 0;
  logic [3:0] bus_addr = 4'h0;
  logic [7:0] bus_wdata = 8'h00, bus_rdata;
  logic [1:0] card_clock_contact;
  logic [2:0] card_io_in, card_io_out, card_io_oe_n, pull = 3'h0, osel = 3'h0;
  cce_card_type card_select_field = CCE_SEL_A;
  int mismatches = 0, checks_done = 0, cyc = 0, gcnt = 0, pcnt = 0, rc = 0;
  logic [7:0] bq[$], mq[$];
  int pq[$], gq[$];
  cce_card_config DUT (.*);
  cce_card_model u_card (.card_io_oe_n, .card_io_in, .card_pull(pull));
  always #2 mclk = ~mclk;
  // Crystal enable every second cycle, ring every third, so the two line up once every six cycles.
  always @(posedge mclk)
  begin
    xtal_tick <= ~xtal_tick;
    rc <= (rc == 2) ? 0 : rc + 1;
    ring_tick <= (rc == 2);
  end
  task automatic summarize();
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_int(input int g, input int e);
    checks_done++;
    if (g != e)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Watcher: takes the oldest note whenever a result shows up.
  always @(posedge mclk)
  begin
    logic [7:0] v;
    v = (osel == 0) ? {7'h00, card_clock_contact[0]} : (osel == 1) ? {7'h00, irq_n} :
      (osel == 2) ? {7'h00, xtal_stop} : (osel == 3) ? {5'h00, card_io_oe_n} :
      {7'h00, convention_bit};
    if (bus_rd)
      v = bus_rdata & mq[0];
    if ((bus_rd || oen) && bq.size() > 0)
      cmp_byte(v, bq.pop_front() & mq.pop_front());
    if (etu_tick && meas && pq.size() > 0)
      cmp_int(pcnt, pq.pop_front());
    if (uart_send_go && gq.size() > 0)
      cmp_int(gcnt, gq.pop_front());
    pcnt <= etu_tick ? 1 : pcnt + 1;
    gcnt <= (bus_wr && bus_addr == 4'hD) ? 0 : gcnt + etu_tick;
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      mismatches++;
      summarize();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge mclk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    bq.push_back(e);
    mq.push_back(m);
    @(posedge mclk);
    bus_rd <= 1'b0;
  endtask
  task automatic ob(input logic [2:0] s, input logic [7:0] e);
    repeat (40) @(posedge mclk);
    osel <= s;
    oen <= 1'b1;
    bq.push_back(e);
    mq.push_back(8'hFF);
    @(posedge mclk);
    oen <= 1'b0;
  endtask
  // Waits under a bound for an ETU tick, a send release or the end of power-down.
  task automatic wait_for(input int w);
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (((w == 0) ? etu_tick : (w == 1) ? uart_send_go : !xtal_stop) !== 1'b1 && n < 5000);
    if (n >= 5000)
      mismatches++;
  endtask
  initial
  begin
    static logic [3:0] ad[4] = '{4'h1, 4'h2, 4'h3, 4'h5};
    static logic [7:0] wm[4] = '{8'h3F, 8'hFF, 8'h6F, 8'hFF};
    static logic [7:0] xb[4] = '{8'hC0, 8'h00, 8'h80, 8'h00};
    static logic [7:0] ec[9] = '{0, 0, 0, 1, 1, 0, 2, 3, 4};
    static logic [7:0] eu[9] = '{0, 0, 1, 0, 2, 2, 0, 0, 0};
    static logic [7:0] ep[9] = '{1, 0, 3, 2, 2, 1, 1, 1, 1};
    static int ee[9] = '{124, 124, 384, 496, 248, 124, 496, 992, 372};
    logic [7:0] val[3][4];
    bq.push_back($urandom(32'h3f7e) & 8'h00);
    bq.delete();
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    for (int k = 0; k < 4; k++) rd(ad[k], 8'h00);
    for (int s = 0; s < 3; s++)
    begin
      card_select_field <= cce_card_type'(3'b001 << s);
      for (int k = 0; k < 4; k++)
      begin
        val[s][k] = $urandom() & wm[k];
        wr(ad[k], val[s][k] | xb[k]);
      end
    end
    uart_reset_bit_n <= 1'b0;
    @(posedge mclk);
    uart_reset_bit_n <= 1'b1;
    for (int s = 0; s < 3; s++)
    begin
      card_select_field <= cce_card_type'(3'b001 << s);
      for (int k = 0; k < 4; k++) rd(ad[k], val[s][k]);
      wr(4'h3, 8'h00);
    end
    card_select_field <= CCE_SEL_NONE;
    rd(4'h1, 8'h00);
    card_select_field <= CCE_SEL_A;
    for (int i = 0; i < 9; i++)
    begin
      wr(4'h1, ec[i]);
      wr(4'h3, eu[i]);
      wr(4'h2, ep[i]);
      repeat (2) wait_for(0);
      pq.push_back(ee[i]);
      meas <= 1'b1;
      wait_for(0);
      meas <= 1'b0;
    end
    wr(4'h1, 8'h30);
    rd(4'h1, 8'h30);
    ob(0, 1);
    wr(4'h1, 8'h10);
    ob(0, 0);
    // Synchronous mode: clock and I/O follow the registers directly.
    wr(4'h3, 8'h08);
    wr(4'h1, 8'h08);
    ob(0, 1);
    wr(4'h1, 8'h00);
    ob(0, 0);
    wr(4'hD, 8'hFE);
    ob(3, 3'b110);
    wr(4'hD, 8'h01);
    ob(3, 3'b111);
    pull <= 3'b001;
    repeat (4) @(posedge mclk);
    rd(4'hD, 8'h00, 8'h01);
    pull <= 3'b000;
    repeat (4) @(posedge mclk);
    rd(4'hD, 8'h01, 8'h01);
    card_select_field <= CCE_SEL_AUX;
    wr(4'h3, 8'h08);
    wr(4'hD, 8'h00);
    ob(3, 3'b011);
    wr(4'hD, 8'h01);
    wr(4'h3, 8'h00);
    card_select_field <= CCE_SEL_A;
    // Guard time before each character, then none at all.
    wr(4'h3, 8'h00);
    wr(4'h5, 8'h03);
    gq.push_back(3);
    wr(4'hD, 8'h55);
    wait_for(1);
    wr(4'h5, 8'h00);
    gq.push_back(0);
    wr(4'hD, 8'hAA);
    wait_for(1);
    supply_fault_latch <= 1'b1;
    wr(4'h3, 8'h10);
    ob(2, 0);
    supply_fault_latch <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      wr(4'h3, 8'h10);
      ob(2, 1);
      if (i == 0) card_a_presence_change <= 1'b1;
      if (i == 1) card_b_presence_change <= 1'b1;
      if (i == 2) wr(4'h3, 8'h00);
      if (i == 3) chip_sel_n <= 1'b1;
      if (i == 4) aux_interrupt_input <= ~aux_interrupt_input;
      repeat (4) @(posedge mclk);
      card_a_presence_change <= 1'b0;
      card_b_presence_change <= 1'b0;
      chip_sel_n <= 1'b0;
      wait_for(2);
      ob(1, 0);
      rd(4'hF, (i == 4) ? 8'h02 : 8'h00, 8'h02);
      ob(1, 1);
    end
    // Interrupt sources with and without their disable bits.
    buffer_flag <= 1'b1;
    ob(1, 0);
    wr(4'h3, 8'h40);
    ob(1, 1);
    buffer_flag <= 1'b0;
    wr(4'h3, 8'h60);
    aux_interrupt_input <= ~aux_interrupt_input;
    ob(1, 1);
    rd(4'hF, 8'h02, 8'h02);
    rd(4'hF, 8'h00, 8'h02);
    wr(4'h3, 8'h00);
    aux_interrupt_input <= ~aux_interrupt_input;
    ob(1, 0);
    rd(4'hF, 8'h02, 8'h02);
    ob(1, 1);
    convention_setting <= 1'b1;
    convention_bit_detect_value <= 1'b1;
    convention_bit_detect_valid <= 1'b1;
    @(posedge mclk);
    convention_bit_detect_valid <= 1'b0;
    ob(4, 1);
    wr(4'h3, 8'h04);
    convention_bit_detect_value <= 1'b0;
    convention_bit_detect_valid <= 1'b1;
    @(posedge mclk);
    convention_bit_detect_valid <= 1'b0;
    ob(4, 1);
    summarize();
  end
endmodule // tb_top
